// File: inc/wcsr_map.svh
// constants of the channel select and line reset block
// ============================================================================
`ifndef WCSR_MAP_SVH
`define WCSR_MAP_SVH

// ============================================================================
// command codes
`define WCSR_CMD_CHAN_SEL 8'hc3
`define WCSR_CMD_LINE_RESET 8'hb4

// ============================================================================
// selection codes, written form, channel zero first
`define WCSR_SEL_WR0 8'hf0
`define WCSR_SEL_WR1 8'he1
`define WCSR_SEL_WR2 8'hd2
`define WCSR_SEL_WR3 8'hc3
`define WCSR_SEL_WR4 8'hb4
`define WCSR_SEL_WR5 8'ha5
`define WCSR_SEL_WR6 8'h96
`define WCSR_SEL_WR7 8'h87

// ============================================================================
// selection codes, read-back form
`define WCSR_SEL_RD0 8'hb8
`define WCSR_SEL_RD1 8'hb1
`define WCSR_SEL_RD2 8'haa
`define WCSR_SEL_RD3 8'ha3
`define WCSR_SEL_RD4 8'h9c
`define WCSR_SEL_RD5 8'h95
`define WCSR_SEL_RD6 8'h8e
`define WCSR_SEL_RD7 8'h87

// ============================================================================
// reset values
`define WCSR_CHAN_RESET 3'h0

// ============================================================================
// timing, in ns, and clock periods in ps
`define WCSR_SYS_CLK_PS 25000
`define WCSR_LINK_CLK_PS 6000
`define WCSR_START_MAX_NS 262.5
`define WCSR_RSTL_STD_NS 480000
`define WCSR_RSTH_STD_NS 480000
`define WCSR_SI_STD_NS 8000
`define WCSR_MSP_STD_NS 70000
`define WCSR_RSTL_FST_NS 48000
`define WCSR_RSTH_FST_NS 48000
`define WCSR_SI_FST_NS 1000
`define WCSR_MSP_FST_NS 7000

`endif

// File: inc/wcsr_pkg.sv
// types of the channel select and line reset block
package wcsr_pkg;

    // one byte handed over by the serial host receiver
    typedef struct packed {
        logic is_cmd;
        logic [7:0] data;
    } wcsr_byte_t;

    // request passed to the line domain, stable while the cycle runs
    typedef struct packed {
        logic fast;
        logic [2:0] chan;
    } wcsr_req_t;

    // status flags seen by the host
    typedef struct packed {
        logic line_busy_flag;
        logic presence_detected_flag;
        logic short_detected_flag;
    } wcsr_status_t;

    typedef enum logic [1:0] {
        WCSR_PTR_STATUS,
        WCSR_PTR_READ_DATA,
        WCSR_PTR_CHAN_SEL,
        WCSR_PTR_CONFIG
    } wcsr_rptr_t;

    typedef enum logic [2:0] {
        WCSR_C_IDLE,
        WCSR_C_SEL_PARAM,
        WCSR_C_SEL_ACK,
        WCSR_C_RST_ACK,
        WCSR_C_IGNORE
    } wcsr_cmd_state_t;

    typedef enum logic [1:0] {
        WCSR_L_IDLE,
        WCSR_L_LOW,
        WCSR_L_HIGH
    } wcsr_link_state_t;

endpackage : wcsr_pkg

// File: hdl/wcsr_sync.sv
// two flip-flop synchroniser for levels entering a clock domain
`timescale 1ns/10ps
module wcsr_sync #(
    parameter int W = 1
) (
    // clock and reset of the receiving domain
    input wire logic i_clk,
    input wire logic i_nrst,
    // level in, level out
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] q_reg;
    logic [W-1:0] q_next;

    // the first stage feeds only the second stage
    always_comb begin
        meta_next = i_d;
        q_next = meta_reg;
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            meta_reg <= '0;
            q_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            q_reg <= q_next;
        end
    end

    assign o_q = q_reg;
endmodule : wcsr_sync

// File: hdl/wcsr_top.sv
// channel select and line reset command handling of the serial-to-line bridge
`timescale 1ns/10ps
`include "wcsr_map.svh"
module wcsr_top #(
    // link-clock cycle counts, standard and fast speed
    parameter int unsigned P_RSTL_STD_CYC = `WCSR_RSTL_STD_NS * 1000 / `WCSR_LINK_CLK_PS,
    parameter int unsigned P_RSTH_STD_CYC = `WCSR_RSTH_STD_NS * 1000 / `WCSR_LINK_CLK_PS,
    parameter int unsigned P_SI_STD_CYC = `WCSR_SI_STD_NS * 1000 / `WCSR_LINK_CLK_PS,
    parameter int unsigned P_MSP_STD_CYC = `WCSR_MSP_STD_NS * 1000 / `WCSR_LINK_CLK_PS,
    parameter int unsigned P_RSTL_FST_CYC = `WCSR_RSTL_FST_NS * 1000 / `WCSR_LINK_CLK_PS,
    parameter int unsigned P_RSTH_FST_CYC = `WCSR_RSTH_FST_NS * 1000 / `WCSR_LINK_CLK_PS,
    parameter int unsigned P_SI_FST_CYC = `WCSR_SI_FST_NS * 1000 / `WCSR_LINK_CLK_PS,
    parameter int unsigned P_MSP_FST_CYC = `WCSR_MSP_FST_NS * 1000 / `WCSR_LINK_CLK_PS
) (
    // system clock and reset
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    // line timing clock
    input wire logic i_link_clk,
    // bytes from the serial host receiver
    input wire logic i_byte_strb,
    input wire wcsr_pkg::wcsr_byte_t i_byte,
    input wire logic i_ack_scl_rise,
    input wire logic i_ack_scl_fall,
    output logic o_ack,
    // configuration
    input wire logic i_fast_speed_select,
    // state seen by the host
    output wcsr_pkg::wcsr_status_t o_status,
    output logic [2:0] o_chan_index,
    output logic [7:0] o_chan_readback,
    output wcsr_pkg::wcsr_rptr_t o_read_ptr,
    // eight open-drain line channels
    input wire logic [7:0] i_line_in,
    output logic [7:0] o_line_out,
    output logic [7:0] o_line_oe
);
    import wcsr_pkg::*;

    localparam int CW = 17;

    // ========================================================================
    // system domain: command decode
    wcsr_cmd_state_t cst_reg, cst_next;
    logic ack_reg, ack_next;
    logic [2:0] chan_reg, chan_next;
    logic [2:0] pend_reg, pend_next;
    wcsr_rptr_t ptr_reg, ptr_next;
    logic busy_reg, busy_next;
    logic start_tgl_reg, start_tgl_next;
    wcsr_req_t req_reg, req_next;
    logic done_seen_reg, done_seen_next;
    logic [7:0] rdbk_reg, rdbk_next;
    logic sel_valid;
    logic [2:0] sel_index;
    logic done_sync;
    logic [1:0] flags_sync;
    logic done_tgl_reg;

    // selection code to channel index
    always_comb begin
        sel_valid = 1'b1;
        sel_index = 3'h0;
        unique case (i_byte.data)
            `WCSR_SEL_WR0: sel_index = 3'h0;
            `WCSR_SEL_WR1: sel_index = 3'h1;
            `WCSR_SEL_WR2: sel_index = 3'h2;
            `WCSR_SEL_WR3: sel_index = 3'h3;
            `WCSR_SEL_WR4: sel_index = 3'h4;
            `WCSR_SEL_WR5: sel_index = 3'h5;
            `WCSR_SEL_WR6: sel_index = 3'h6;
            `WCSR_SEL_WR7: sel_index = 3'h7;
            default: sel_valid = 1'b0;
        endcase
    end

    // command sequencing; busy is sampled as the command byte arrives
    always_comb begin
        cst_next = cst_reg;
        ack_next = ack_reg;
        chan_next = chan_reg;
        pend_next = pend_reg;
        ptr_next = ptr_reg;
        busy_next = busy_reg;
        start_tgl_next = start_tgl_reg;
        req_next = req_reg;
        done_seen_next = done_sync;
        if (i_byte_strb && i_byte.is_cmd) begin
            ack_next = 1'b0;
            cst_next = WCSR_C_IDLE;
            if (i_byte.data == `WCSR_CMD_CHAN_SEL) begin
                ack_next = !busy_reg;
                cst_next = busy_reg ? WCSR_C_IGNORE : WCSR_C_SEL_PARAM;
            end else if (i_byte.data == `WCSR_CMD_LINE_RESET) begin
                ack_next = !busy_reg;
                cst_next = busy_reg ? WCSR_C_IDLE : WCSR_C_RST_ACK;
            end
        end else begin
            unique case (cst_reg)
                WCSR_C_IDLE: begin
                end
                WCSR_C_IGNORE: begin
                    // parameter of a refused command is also refused
                    if (i_byte_strb) begin
                        ack_next = 1'b0;
                        cst_next = WCSR_C_IDLE;
                    end
                end
                WCSR_C_SEL_PARAM: begin
                    if (i_byte_strb) begin
                        ack_next = sel_valid;
                        pend_next = sel_index;
                        cst_next = sel_valid ? WCSR_C_SEL_ACK : WCSR_C_IDLE;
                    end
                end
                WCSR_C_SEL_ACK: begin
                    // no line activity and no status change here
                    if (i_ack_scl_rise) begin
                        chan_next = pend_reg;
                        ptr_next = WCSR_PTR_CHAN_SEL;
                        cst_next = WCSR_C_IDLE;
                    end
                end
                WCSR_C_RST_ACK: begin
                    // start is launched on the acknowledge falling edge
                    if (i_ack_scl_fall) begin
                        busy_next = 1'b1;
                        start_tgl_next = !start_tgl_reg;
                        req_next = '{fast: i_fast_speed_select, chan: chan_reg};
                        ptr_next = WCSR_PTR_STATUS;
                        cst_next = WCSR_C_IDLE;
                    end
                end
            endcase
        end
        // the line domain answers each start with a toggle of its own
        if (done_sync != done_seen_reg) begin
            busy_next = 1'b0;
        end
    end

    // read-back form of the selected channel
    always_comb begin
        unique case (chan_next)
            3'h0: rdbk_next = `WCSR_SEL_RD0;
            3'h1: rdbk_next = `WCSR_SEL_RD1;
            3'h2: rdbk_next = `WCSR_SEL_RD2;
            3'h3: rdbk_next = `WCSR_SEL_RD3;
            3'h4: rdbk_next = `WCSR_SEL_RD4;
            3'h5: rdbk_next = `WCSR_SEL_RD5;
            3'h6: rdbk_next = `WCSR_SEL_RD6;
            3'h7: rdbk_next = `WCSR_SEL_RD7;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cst_reg <= WCSR_C_IDLE;
            ack_reg <= 1'b0;
            chan_reg <= `WCSR_CHAN_RESET;
            pend_reg <= 3'h0;
            ptr_reg <= WCSR_PTR_STATUS;
            busy_reg <= 1'b0;
            start_tgl_reg <= 1'b0;
            req_reg <= '0;
            done_seen_reg <= 1'b0;
            rdbk_reg <= `WCSR_SEL_RD0;
        end else begin
            cst_reg <= cst_next;
            ack_reg <= ack_next;
            chan_reg <= chan_next;
            pend_reg <= pend_next;
            ptr_reg <= ptr_next;
            busy_reg <= busy_next;
            start_tgl_reg <= start_tgl_next;
            req_reg <= req_next;
            done_seen_reg <= done_seen_next;
            rdbk_reg <= rdbk_next;
        end
    end

    // ========================================================================
    // crossings between the domains
    logic start_sync;
    logic [7:0] line_sync;
    logic presence_reg, short_reg;

    // flags and done toggle into the system domain
    wcsr_sync #(.W(3)) u_to_sys (
        .i_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_d({done_tgl_reg, presence_reg, short_reg}),
        .o_q({done_sync, flags_sync})
    );

    // start toggle into the line domain; the request word is quasi-static
    wcsr_sync #(.W(1)) u_to_link (
        .i_clk(i_link_clk),
        .i_nrst(i_nrst),
        .i_d(start_tgl_reg),
        .o_q(start_sync)
    );

    // line pins are asynchronous to every clock
    wcsr_sync #(.W(8)) u_line_in (
        .i_clk(i_link_clk),
        .i_nrst(i_nrst),
        .i_d(i_line_in),
        .o_q(line_sync)
    );

    // ========================================================================
    // line domain: reset and presence cycle
    wcsr_link_state_t lst_reg, lst_next;
    logic [CW-1:0] cnt_reg, cnt_next;
    logic start_seen_reg, start_seen_next;
    logic done_tgl_next;
    logic presence_next, short_next;
    logic fast_reg, fast_next;
    logic [2:0] lchan_reg, lchan_next;
    logic [7:0] oe_reg, oe_next;
    logic [CW-1:0] rstl_cyc, rsth_cyc, si_cyc, msp_cyc;
    logic line_now;

    // speed picks the timing set; counts are fixed at build time
    always_comb begin
        rstl_cyc = fast_reg ? CW'(P_RSTL_FST_CYC) : CW'(P_RSTL_STD_CYC);
        rsth_cyc = fast_reg ? CW'(P_RSTH_FST_CYC) : CW'(P_RSTH_STD_CYC);
        si_cyc = fast_reg ? CW'(P_SI_FST_CYC) : CW'(P_SI_STD_CYC);
        msp_cyc = fast_reg ? CW'(P_MSP_FST_CYC) : CW'(P_MSP_STD_CYC);
        line_now = line_sync[lchan_reg];
    end

    // low phase drives the chosen channel, high phase samples it
    always_comb begin
        lst_next = lst_reg;
        cnt_next = cnt_reg + CW'(1);
        start_seen_next = start_sync;
        done_tgl_next = done_tgl_reg;
        presence_next = presence_reg;
        short_next = short_reg;
        fast_next = fast_reg;
        lchan_next = lchan_reg;
        oe_next = 8'h00;
        unique case (lst_reg)
            WCSR_L_IDLE: begin
                cnt_next = '0;
                if (start_sync != start_seen_reg) begin
                    fast_next = req_reg.fast;
                    lchan_next = req_reg.chan;
                    oe_next = 8'h01 << req_reg.chan;
                    lst_next = WCSR_L_LOW;
                end
            end
            WCSR_L_LOW: begin
                oe_next = 8'h01 << lchan_reg;
                if (cnt_reg == rstl_cyc - CW'(1)) begin
                    oe_next = 8'h00;
                    cnt_next = '0;
                    lst_next = WCSR_L_HIGH;
                end
            end
            WCSR_L_HIGH: begin
                if (cnt_reg == si_cyc) begin
                    short_next = !line_now;
                end
                if (cnt_reg == msp_cyc) begin
                    presence_next = !line_now;
                end
                if (cnt_reg == rsth_cyc - CW'(1)) begin
                    done_tgl_next = !done_tgl_reg;
                    lst_next = WCSR_L_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_link_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            lst_reg <= WCSR_L_IDLE;
            cnt_reg <= '0;
            start_seen_reg <= 1'b0;
            done_tgl_reg <= 1'b0;
            presence_reg <= 1'b0;
            short_reg <= 1'b0;
            fast_reg <= 1'b0;
            lchan_reg <= 3'h0;
            oe_reg <= 8'h00;
        end else begin
            lst_reg <= lst_next;
            cnt_reg <= cnt_next;
            start_seen_reg <= start_seen_next;
            done_tgl_reg <= done_tgl_next;
            presence_reg <= presence_next;
            short_reg <= short_next;
            fast_reg <= fast_next;
            lchan_reg <= lchan_next;
            oe_reg <= oe_next;
        end
    end

    // ========================================================================
    // outputs; the flag pair is registered behind its synchroniser
    logic [1:0] flags_reg;
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            flags_reg <= 2'b00;
        end else begin
            flags_reg <= flags_sync;
        end
    end

    assign o_ack = ack_reg;
    assign o_status = '{line_busy_flag: busy_reg, presence_detected_flag: flags_reg[1],
                        short_detected_flag: flags_reg[0]};
    assign o_chan_index = chan_reg;
    assign o_chan_readback = rdbk_reg;
    assign o_read_ptr = ptr_reg;
    assign o_line_out = 8'h00; // open drain: only ever pulls low
    assign o_line_oe = oe_reg;

    // ========================================================================
    // checks; two clock domains here, so every property names its own clock
    sequence sel_cmd_s;
        i_byte_strb && i_byte.is_cmd && i_byte.data == `WCSR_CMD_CHAN_SEL;
    endsequence
    sequence rst_cmd_s;
        i_byte_strb && i_byte.is_cmd && i_byte.data == `WCSR_CMD_LINE_RESET;
    endsequence
    busy_sel_nack_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        (sel_cmd_s and busy_reg) |=> !o_ack && cst_reg == WCSR_C_IGNORE)
        else $error("channel select acknowledged while busy");
    busy_rst_nack_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        (rst_cmd_s and busy_reg) |=> !o_ack && cst_reg == WCSR_C_IDLE)
        else $error("line reset acknowledged while busy");
    bad_code_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        cst_reg == WCSR_C_SEL_PARAM && i_byte_strb && !i_byte.is_cmd && !sel_valid
        |=> !o_ack && $stable(o_chan_index))
        else $error("invalid selection code accepted");
    chan_update_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        cst_reg == WCSR_C_SEL_ACK && i_ack_scl_rise && !i_byte_strb
        |=> o_chan_index == $past(pend_reg) && o_read_ptr == WCSR_PTR_CHAN_SEL)
        else $error("channel not updated at acknowledge rise");
    chan_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        !(cst_reg == WCSR_C_SEL_ACK && i_ack_scl_rise) |=> $stable(o_chan_index))
        else $error("channel changed outside a select command");
    readback_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        ##1 o_chan_index == 3'h7 |-> o_chan_readback == `WCSR_SEL_RD7)
        else $error("read-back code wrong for channel seven");
    rst_start_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        cst_reg == WCSR_C_RST_ACK && i_ack_scl_fall && !i_byte_strb
        |=> o_status.line_busy_flag && o_read_ptr == WCSR_PTR_STATUS
            && start_tgl_reg != $past(start_tgl_reg))
        else $error("reset cycle not launched at acknowledge fall");
    busy_no_sel_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        busy_reg |-> cst_reg != WCSR_C_SEL_ACK)
        else $error("channel select in progress during busy");
    low_len_a: assert property (@(posedge i_link_clk) disable iff (!i_nrst)
        $past(lst_reg) == WCSR_L_LOW && lst_reg == WCSR_L_HIGH |-> $past(cnt_reg) == rstl_cyc - CW'(1))
        else $error("reset low phase has the wrong length");
    drive_chan_a: assert property (@(posedge i_link_clk) disable iff (!i_nrst)
        lst_reg == WCSR_L_LOW && cnt_reg != '0 |-> o_line_oe == (8'h01 << lchan_reg))
        else $error("reset driven on the wrong channel");
    start_fast_a: assert property (@(posedge i_link_clk) disable iff (!i_nrst)
        lst_reg == WCSR_L_IDLE && start_sync != start_seen_reg |=> o_line_oe != 8'h00)
        else $error("line drive late after start");
endmodule : wcsr_top

// File: sim/wcsr_line_model.sv
// partner model: single-wire slave devices on the eight channels
`timescale 1ns/10ps
module wcsr_line_model #(
    parameter int P_PD_LO = 8,
    parameter int P_PD_HI = 40
) (
    // link clock and reset
    input wire logic i_link_clk,
    input wire logic i_nrst,
    // slave behaviour per channel
    input wire logic [7:0] i_present,
    input wire logic [7:0] i_shorted,
    // bridge drive and line level back
    input wire logic [7:0] i_line_out,
    input wire logic [7:0] i_line_oe,
    output logic [7:0] o_line_in
);
    // ========================================================================
    // presence answer
    int cnt [8];
    // link cycles since release; starts saturated so no answer follows reset
    always @(posedge i_link_clk or negedge i_nrst) begin
        for (int n = 0; n < 8; n++) begin
            if (!i_nrst) begin
                cnt[n] <= 1000;
            end else if (i_line_oe[n]) begin
                cnt[n] <= 0;
            end else if (cnt[n] < 1000) begin
                cnt[n] <= cnt[n] + 1;
            end
        end
    end
    // answer window covers the presence instant, not the short instant
    always_comb begin
        for (int n = 0; n < 8; n++) begin
            o_line_in[n] = ~((i_line_oe[n] & ~i_line_out[n]) | i_shorted[n]
                | (i_present[n] && cnt[n] >= P_PD_LO && cnt[n] < P_PD_HI));
        end
    end
endmodule : wcsr_line_model

// File: sim/wire_channel_select_and_reset_tb.sv
// self-checking bench of the channel select and line reset block
`timescale 1ns/10ps
`include "wcsr_map.svh"
module wire_channel_select_and_reset_tb;
    import wcsr_pkg::*;
    // ========================================================================
    // short link counts keep each reset cycle brief
    localparam int RL = 40;
    localparam int RH = 60;
    localparam int FRL = 20;
    localparam int FRH = 30;
    logic i_sys_clk = 1'b0;
    logic i_link_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_byte_strb = 1'b0;
    wcsr_byte_t i_byte = '0;
    logic i_ack_scl_rise = 1'b0;
    logic i_ack_scl_fall = 1'b0;
    logic i_fast_speed_select = 1'b0;
    logic [7:0] i_present = 8'h00;
    logic [7:0] i_shorted = 8'h00;
    wcsr_status_t o_status;
    wcsr_rptr_t o_read_ptr;
    logic o_ack;
    logic [2:0] o_chan_index;
    logic [7:0] o_chan_readback, i_line_in, o_line_out, o_line_oe, bad;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    int i;
    logic [2:0] k;
    realtime t_edge;
    logic [31:0] rng = 32'h21b0;
    logic [7:0] wr_tab [8] = '{8'hf0, 8'he1, 8'hd2, 8'hc3, 8'hb4, 8'ha5, 8'h96, 8'h87};
    logic [7:0] rd_tab [8] = '{8'hb8, 8'hb1, 8'haa, 8'ha3, 8'h9c, 8'h95, 8'h8e, 8'h87};
    // ========================================================================
    // clocks, unrelated in phase; the link clock runs free
    initial forever #12.5 i_sys_clk = ~i_sys_clk;
    initial begin
        #1.7;
        forever #3 i_link_clk = ~i_link_clk;
    end
    wcsr_top #(.P_RSTL_STD_CYC(RL), .P_RSTH_STD_CYC(RH), .P_SI_STD_CYC(5), .P_MSP_STD_CYC(20),
        .P_RSTL_FST_CYC(FRL), .P_RSTH_FST_CYC(FRH), .P_SI_FST_CYC(3), .P_MSP_FST_CYC(10)) i_dut (
        .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_link_clk(i_link_clk), .i_byte_strb(i_byte_strb),
        .i_byte(i_byte), .i_ack_scl_rise(i_ack_scl_rise), .i_ack_scl_fall(i_ack_scl_fall), .o_ack(o_ack),
        .i_fast_speed_select(i_fast_speed_select), .o_status(o_status), .o_chan_index(o_chan_index),
        .o_chan_readback(o_chan_readback), .o_read_ptr(o_read_ptr), .i_line_in(i_line_in),
        .o_line_out(o_line_out), .o_line_oe(o_line_oe));
    wcsr_line_model i_line (.i_link_clk(i_link_clk), .i_nrst(i_nrst), .i_present(i_present),
        .i_shorted(i_shorted), .i_line_out(o_line_out), .i_line_oe(o_line_oe), .o_line_in(i_line_in));
    // ========================================================================
    // helpers
    function automatic logic [31:0] xorshift();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : xorshift
    // flags after a cycle: a shorted line reads low at both instants
    function automatic logic [7:0] exp_flags(input int mode);
        return {6'h00, mode != 0, mode == 2};
    endfunction : exp_flags
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic send_byte(input logic c, input logic [7:0] d);
        @(posedge i_sys_clk);
        i_byte_strb <= 1'b1;
        i_byte <= {c, d};
        @(posedge i_sys_clk);
        i_byte_strb <= 1'b0;
        #1;
    endtask : send_byte
    // one acknowledge SCL edge pulse; outputs read one edge later
    task automatic pulse(input logic fall);
        @(posedge i_sys_clk);
        // timing is counted from the edge that raises the pulse, the stricter reading
        t_edge = $realtime;
        if (fall) i_ack_scl_fall <= 1'b1;
        else i_ack_scl_rise <= 1'b1;
        @(posedge i_sys_clk);
        i_ack_scl_fall <= 1'b0;
        i_ack_scl_rise <= 1'b0;
        @(posedge i_sys_clk);
        #1;
    endtask : pulse
    task automatic sel_chan(input logic [7:0] code, input logic ok, input logic [2:0] ch);
        logic [7:0] st;
        st = 8'(o_status);
        send_byte(1'b1, `WCSR_CMD_CHAN_SEL);
        check(8'(o_ack), 8'h01);
        send_byte(1'b0, code);
        check(8'(o_ack), 8'(ok));
        pulse(1'b0);
        check(8'(o_chan_index), 8'(ch));
        check(o_chan_readback, rd_tab[ch]);
        check(8'(o_status), st);
        check(o_line_oe, 8'h00);
        if (ok) check(8'(o_read_ptr), 8'(WCSR_PTR_CHAN_SEL));
    endtask : sel_chan
    // mode 0 no slave, 1 slave answers, 2 line shorted; strong pullup never asked
    task automatic line_reset(input logic [2:0] ch, input logic fast, input int mode, input logic poke);
        realtime t0;
        int n;
        int tot;
        @(posedge i_sys_clk);
        i_fast_speed_select <= fast;
        i_present <= 8'((xorshift() & ~(8'h01 << ch)) | (8'(mode == 1) << ch));
        i_shorted <= 8'(mode == 2) << ch;
        send_byte(1'b1, `WCSR_CMD_LINE_RESET);
        check(8'(o_ack), 8'h01);
        pulse(1'b1);
        t0 = t_edge;
        check(8'(o_status.line_busy_flag), 8'h01);
        check(8'(o_read_ptr), 8'(WCSR_PTR_STATUS));
        for (n = 0; n < 300 && o_line_oe === 8'h00; n++) #1;
        check(8'($realtime - t0 <= 262.5), 8'h01);
        check(o_line_oe, 8'h01 << ch);
        check(o_line_out, 8'h00);
        if (poke) begin
            send_byte(1'b1, `WCSR_CMD_CHAN_SEL);
            check(8'(o_ack), 8'h00);
            send_byte(1'b0, wr_tab[~ch]);
            check(8'(o_ack), 8'h00);
            pulse(1'b0);
            check(8'(o_chan_index), 8'(ch));
            send_byte(1'b1, `WCSR_CMD_LINE_RESET);
            check(8'(o_ack), 8'h00);
            pulse(1'b1);
        end
        for (n = 0; n < 3000 && o_status.line_busy_flag !== 1'b0; n++) #1;
        tot = fast ? (FRL + FRH) * 6 : (RL + RH) * 6;
        check(8'($realtime - t0 >= tot && $realtime - t0 <= tot + 262.5), 8'h01);
        repeat (4) @(posedge i_sys_clk);
        #1;
        check(8'(o_status), exp_flags(mode));
        check(o_line_oe, 8'h00);
    endtask : line_reset
    // ========================================================================
    // hang guard
    always @(posedge i_sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    // ========================================================================
    // main sequence
    initial begin
        repeat (4) @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        #1;
        check(8'(o_ack), 8'h00);
        check(8'(o_status), 8'h00);
        check(8'(o_chan_index), 8'h00);
        check(o_chan_readback, 8'hb8);
        check(8'(o_read_ptr), 8'(WCSR_PTR_STATUS));
        $display("test reset values done");
        // every code once, in a scrambled order
        k = 3'(xorshift());
        for (i = 0; i < 8; i++) begin
            k = k + 3'h3;
            sel_chan(wr_tab[k], 1'b1, k);
        end
        $display("test channel select done");
        for (i = 0; i < 4; i++) begin
            bad = 8'(xorshift());
            if (bad[3:0] == ~bad[7:4]) bad ^= 8'h01;
            sel_chan(bad, 1'b0, k);
        end
        $display("test invalid codes done");
        // both speeds, all three line outcomes, busy refusals in the first
        for (i = 0; i < 6; i++) begin
            k = 3'(xorshift());
            sel_chan(wr_tab[k], 1'b1, k);
            line_reset(k, i[0], i % 3, i == 0);
        end
        $display("test line reset done");
        report_and_stop();
    end
endmodule : wire_channel_select_and_reset_tb
